//--- simdfe_pkg.sv
`default_nettype none

package simdfe_pkg;

    // ---------------------------------------------------------------
    // Geometry and register map
    // ---------------------------------------------------------------
    localparam int LANES = 4;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_UNIT_STATE = 4'h4;

    // ---------------------------------------------------------------
    // Control/status fields
    // ---------------------------------------------------------------
    localparam int BIT_INVALID_FLAG = 0;
    localparam int BIT_DENORMAL_FLAG = 1;
    localparam int BIT_DIVZERO_FLAG = 2;
    localparam int BIT_OVERFLOW_FLAG = 3;
    localparam int BIT_UNDERFLOW_FLAG = 4;
    localparam int BIT_INEXACT_FLAG = 5;
    localparam int BIT_DAZ = 6;
    localparam int BIT_INVALID_MASK = 7;
    localparam int BIT_DENORMAL_MASK = 8;
    localparam int BIT_DIVZERO_MASK = 9;
    localparam int BIT_OVERFLOW_MASK = 10;
    localparam int BIT_UNDERFLOW_MASK = 11;
    localparam int BIT_INEXACT_MASK = 12;
    localparam int BIT_FTZ = 15;
    localparam int BIT_OS_SIMD_FAULT_ENABLE = 10;
    localparam int FLAG_LSB = 0;
    localparam int MASK_LSB = 7;
    localparam int NCOND = 6;

    localparam logic [31:0] CTRL_RESET = 32'h0000_1f80;
    localparam logic [31:0] CTRL_WRITABLE = 32'h0000_ffff;

    // ---------------------------------------------------------------
    // Instruction classes and sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_ARITH = 3'h0,
        KIND_DIV_DOUBLE = 3'h1,
        KIND_CMP_ORDERED = 3'h2,
        KIND_CMP_SIGNALING = 3'h3,
        KIND_CMP_QUIET = 3'h4,
        KIND_CONVERT = 3'h5,
        KIND_RECIP_APPROX = 3'h6
    } simdfe_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FAULT_PRE = 3'h1,
        ST_WAIT_RESULT = 3'h2,
        ST_FAULT_POST = 3'h3
    } simdfe_state_t;

endpackage : simdfe_pkg

`default_nettype wire

//--- simdfe_exception_unit.sv
// What this block does
// - Unmasked invalid faults and holds all operands
// - Quiet NaN invalid only for signaling compares
// - Invalid, divzero, overflow ignore flush-to-zero
// - Denormal input sets flag bit 1, mask 8
// - Conversions and approximations never flag denormal
// - Denormals-as-zero replaces denormal with signed zero
// - Double divide of finite nonzero by zero
// - Rounded result too large flags overflow
// - Masked underflow needs tiny and inexact
// - Underflow flag bit 4, mask bit 11
// - Flush-to-zero with masked underflow zeroes tiny results
// - Unrepresentable result raises inexact, mask bit 12
// - Inexact still reported under flush-to-zero
// - Pre-compute checks before post-compute checks
// - Fault may be raised once per phase
// - All masked: write results, no fault
// - Masked tiny exact result leaves underflow flag, except under flush-to-zero
// - Per-lane flags ORed into status flags
// - Unmasked pre conditions flag, hold and fault in one cycle
// - OS enable picks SIMD fault or invalid-opcode
// - Handler return resumes at post-compute checking
// - Invalid flag bit 0, mask bit 7
// - Unmasked post conditions flag, hold, fault, complete
// - Masked results withheld until unmasked faults handled
`default_nettype none

module simdfe_exception_unit (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [simdfe_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [31:0] i_system_control_reg,
    input wire logic i_op_valid,
    input wire logic [2:0] i_op_kind,
    input wire logic [simdfe_pkg::LANES-1:0] i_lane_en,
    input wire logic [simdfe_pkg::LANES-1:0] i_src_snan,
    input wire logic [simdfe_pkg::LANES-1:0] i_src_qnan,
    input wire logic [simdfe_pkg::LANES-1:0] i_src_bad_arith,
    input wire logic [simdfe_pkg::LANES-1:0] i_src_denormal,
    input wire logic [simdfe_pkg::LANES-1:0] i_src_sign,
    input wire logic [simdfe_pkg::LANES-1:0] i_divisor_zero,
    input wire logic [simdfe_pkg::LANES-1:0] i_dividend_finite_nz,
    input wire logic i_res_valid,
    input wire logic [simdfe_pkg::LANES-1:0] i_res_overflow,
    input wire logic [simdfe_pkg::LANES-1:0] i_res_tiny,
    input wire logic [simdfe_pkg::LANES-1:0] i_res_inexact,
    input wire logic [simdfe_pkg::LANES-1:0] i_res_sign,
    input wire logic i_handler_return,
    output logic o_busy,
    output logic o_compute_go,
    output logic o_commit,
    output logic o_hold_operands,
    output logic o_simd_fp_fault,
    output logic o_invalid_opcode_fault,
    output logic [simdfe_pkg::LANES-1:0] o_src_zero,
    output logic [simdfe_pkg::LANES-1:0] o_src_zero_sign,
    output logic [simdfe_pkg::LANES-1:0] o_res_flush,
    output logic [simdfe_pkg::LANES-1:0] o_res_flush_sign
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // A quiet NaN only counts as invalid for the signaling compare forms.
    function automatic logic qnan_signals(input logic [2:0] kind);
        qnan_signals = (kind == simdfe_pkg::KIND_CMP_ORDERED) ||
                       (kind == simdfe_pkg::KIND_CMP_SIGNALING);
    endfunction : qnan_signals

    function automatic logic any_lane(input logic [simdfe_pkg::LANES-1:0] v);
        any_lane = |v;
    endfunction : any_lane

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    simdfe_pkg::simdfe_state_t state_q;
    simdfe_pkg::simdfe_state_t state_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] rdata_q;
    logic compute_go_q;
    logic commit_q;
    logic hold_q;
    logic simd_fault_q;
    logic opc_fault_q;
    logic last_opc_fault_q;
    logic [simdfe_pkg::LANES-1:0] src_zero_q;
    logic [simdfe_pkg::LANES-1:0] src_zero_sign_q;
    logic [simdfe_pkg::LANES-1:0] flush_q;
    logic [simdfe_pkg::LANES-1:0] flush_sign_q;

    // ---------------------------------------------------------------
    // Control fields
    // ---------------------------------------------------------------
    wire daz_on = ctrl_q[simdfe_pkg::BIT_DAZ];
    wire ftz_on = ctrl_q[simdfe_pkg::BIT_FTZ];
    wire m_inv = ctrl_q[simdfe_pkg::BIT_INVALID_MASK];
    wire m_den = ctrl_q[simdfe_pkg::BIT_DENORMAL_MASK];
    wire m_dz = ctrl_q[simdfe_pkg::BIT_DIVZERO_MASK];
    wire m_ovf = ctrl_q[simdfe_pkg::BIT_OVERFLOW_MASK];
    wire m_unf = ctrl_q[simdfe_pkg::BIT_UNDERFLOW_MASK];
    wire m_inx = ctrl_q[simdfe_pkg::BIT_INEXACT_MASK];
    wire os_fault_en = i_system_control_reg[simdfe_pkg::BIT_OS_SIMD_FAULT_ENABLE];

    // ---------------------------------------------------------------
    // Pre-computation detection, one bit per lane
    // ---------------------------------------------------------------
    wire take_op = i_op_valid && (state_q == simdfe_pkg::ST_IDLE);
    wire take_res = i_res_valid && (state_q == simdfe_pkg::ST_WAIT_RESULT);
    wire no_denorm_kind = (i_op_kind == simdfe_pkg::KIND_CONVERT) ||
                          (i_op_kind == simdfe_pkg::KIND_RECIP_APPROX);
    // None of these terms looks at flush-to-zero.
    wire [simdfe_pkg::LANES-1:0] lane_inv = i_lane_en & (i_src_snan | i_src_bad_arith |
        (i_src_qnan & {simdfe_pkg::LANES{qnan_signals(i_op_kind)}}));
    // With denormals-as-zero the operand is a zero, so nothing is left to flag.
    wire [simdfe_pkg::LANES-1:0] lane_den = i_lane_en & i_src_denormal &
        {simdfe_pkg::LANES{!no_denorm_kind && !daz_on}};
    wire [simdfe_pkg::LANES-1:0] lane_dz = i_lane_en & i_divisor_zero & i_dividend_finite_nz &
        {simdfe_pkg::LANES{i_op_kind == simdfe_pkg::KIND_DIV_DOUBLE}};
    wire pre_inv = any_lane(lane_inv);
    wire pre_den = any_lane(lane_den);
    wire pre_dz = any_lane(lane_dz);
    wire pre_unmasked = (pre_inv && !m_inv) || (pre_den && !m_den) ||
                        (pre_dz && !m_dz);

    // ---------------------------------------------------------------
    // Post-computation detection
    // ---------------------------------------------------------------
    wire [simdfe_pkg::LANES-1:0] lane_flush = i_res_tiny &
        {simdfe_pkg::LANES{ftz_on && m_unf}};
    // A flushed lane lost its value, so it is inexact whatever the mode.
    wire [simdfe_pkg::LANES-1:0] lane_inx = i_res_inexact | lane_flush;
    wire [simdfe_pkg::LANES-1:0] lane_unf = i_res_tiny &
        (lane_inx | {simdfe_pkg::LANES{!m_unf}});
    wire post_ovf = any_lane(i_res_overflow);
    wire post_unf = any_lane(lane_unf);
    wire post_inx = any_lane(lane_inx);
    wire post_unmasked = (post_ovf && !m_ovf) || (post_unf && !m_unf) ||
                         (post_inx && !m_inx);

    // Masked and unmasked conditions all set their flags together.
    wire [simdfe_pkg::NCOND-1:0] flag_set = {
        take_res && post_inx,
        take_res && post_unf,
        take_res && post_ovf,
        take_op && pre_dz,
        take_op && pre_den,
        take_op && pre_inv
    };

    // ---------------------------------------------------------------
    // Register access
    // ---------------------------------------------------------------
    wire wr_ctrl = i_wr && (i_addr == simdfe_pkg::OFF_CTRL_STATUS);
    wire [31:0] unit_state = {27'h0000000, last_opc_fault_q, state_q, o_busy};
    wire [31:0] rd_mux = (i_addr == simdfe_pkg::OFF_CTRL_STATUS) ? ctrl_q :
                         (i_addr == simdfe_pkg::OFF_UNIT_STATE) ? unit_state : 32'h0000_0000;

    // Hardware setting a flag wins over a software write in the same cycle.
    always_comb
    begin
        ctrl_d = wr_ctrl ? (i_wdata & simdfe_pkg::CTRL_WRITABLE) : ctrl_q;
        ctrl_d[simdfe_pkg::FLAG_LSB +: simdfe_pkg::NCOND] =
            ctrl_d[simdfe_pkg::FLAG_LSB +: simdfe_pkg::NCOND] | flag_set;
    end

    // ---------------------------------------------------------------
    // Two-phase sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            simdfe_pkg::ST_IDLE:
            begin
                if (i_op_valid)
                begin
                    state_d = pre_unmasked ? simdfe_pkg::ST_FAULT_PRE :
                              simdfe_pkg::ST_WAIT_RESULT;
                end
            end
            simdfe_pkg::ST_FAULT_PRE:
            begin
                if (i_handler_return)
                begin
                    state_d = simdfe_pkg::ST_WAIT_RESULT;
                end
            end
            simdfe_pkg::ST_WAIT_RESULT:
            begin
                if (i_res_valid)
                begin
                    state_d = post_unmasked ? simdfe_pkg::ST_FAULT_POST :
                              simdfe_pkg::ST_IDLE;
                end
            end
            simdfe_pkg::ST_FAULT_POST:
            begin
                if (i_handler_return)
                begin
                    state_d = simdfe_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_d = simdfe_pkg::ST_IDLE;
            end
        endcase
    end

    wire raise_fault = (take_op && pre_unmasked) || (take_res && post_unmasked);
    wire pre_return = (state_q == simdfe_pkg::ST_FAULT_PRE) && i_handler_return;
    wire post_return = (state_q == simdfe_pkg::ST_FAULT_POST) && i_handler_return;
    wire go_next = (take_op && !pre_unmasked) || pre_return;
    // Results leave only once no unmasked fault is pending.
    wire commit_next = (take_res && !post_unmasked) || post_return;
    wire fault_state = (state_d == simdfe_pkg::ST_FAULT_PRE) ||
                       (state_d == simdfe_pkg::ST_FAULT_POST);

    // ---------------------------------------------------------------
    // Flip-flops
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= simdfe_pkg::ST_IDLE;
            ctrl_q <= simdfe_pkg::CTRL_RESET;
            rdata_q <= 32'h0000_0000;
        end
        else if (i_clk_en)
        begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            compute_go_q <= 1'b0;
            commit_q <= 1'b0;
            hold_q <= 1'b0;
            simd_fault_q <= 1'b0;
            opc_fault_q <= 1'b0;
            last_opc_fault_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            compute_go_q <= go_next;
            commit_q <= commit_next;
            hold_q <= fault_state;
            simd_fault_q <= raise_fault && os_fault_en;
            opc_fault_q <= raise_fault && !os_fault_en;
            if (raise_fault)
            begin
                last_opc_fault_q <= !os_fault_en;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            src_zero_q <= '0;
            src_zero_sign_q <= '0;
            flush_q <= '0;
            flush_sign_q <= '0;
        end
        else if (i_clk_en)
        begin
            if (take_op)
            begin
                src_zero_q <= i_lane_en & i_src_denormal & {simdfe_pkg::LANES{daz_on}};
                src_zero_sign_q <= i_src_sign;
            end
            if (take_res)
            begin
                flush_q <= lane_flush;
                flush_sign_q <= i_res_sign;
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_busy = (state_q != simdfe_pkg::ST_IDLE);
    assign o_compute_go = compute_go_q;
    assign o_commit = commit_q;
    assign o_hold_operands = hold_q;
    assign o_simd_fp_fault = simd_fault_q;
    assign o_invalid_opcode_fault = opc_fault_q;
    assign o_src_zero = src_zero_q;
    assign o_src_zero_sign = src_zero_sign_q;
    assign o_res_flush = flush_q;
    assign o_res_flush_sign = flush_sign_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // A stalled clock enable would stretch every relation, so it disables them.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n || !i_clk_en);

    sequence s_pre_fault;
        take_op && pre_unmasked;
    endsequence
    sequence s_fault_out;
        o_simd_fp_fault || o_invalid_opcode_fault;
    endsequence

    property p_pre_fault;
        s_pre_fault |=> s_fault_out ##0 o_hold_operands;
    endproperty
    a_pre_fault: assert property (p_pre_fault) else $error("pre fault missing");

    property p_fault_kind;
        o_simd_fp_fault |-> $past(os_fault_en) && !o_invalid_opcode_fault;
    endproperty
    a_fault_kind: assert property (p_fault_kind) else $error("wrong fault kind");

    property p_no_go_on_fault;
        s_pre_fault |=> !o_compute_go && !o_commit;
    endproperty
    a_no_go_on_fault: assert property (p_no_go_on_fault) else $error("ran past fault");

    property p_direct_compute;
        take_op && !pre_unmasked |=> o_compute_go ##1 !o_compute_go;
    endproperty
    a_direct_compute: assert property (p_direct_compute) else $error("no compute");

    property p_resume_post;
        pre_return |=> o_compute_go && state_q == simdfe_pkg::ST_WAIT_RESULT;
    endproperty
    a_resume_post: assert property (p_resume_post) else $error("bad resume");

    property p_second_fault;
        take_res && post_unmasked |=> s_fault_out ##0 !o_commit;
    endproperty
    a_second_fault: assert property (p_second_fault) else $error("post fault missing");

    property p_commit;
        take_res && !post_unmasked |=> o_commit && !o_busy;
    endproperty
    a_commit: assert property (p_commit) else $error("no commit");

    property p_flag_sticky;
        $past(ctrl_q[simdfe_pkg::BIT_UNDERFLOW_FLAG]) && !ctrl_q[simdfe_pkg::BIT_UNDERFLOW_FLAG]
            |-> $past(wr_ctrl);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_flush;
        take_res && ftz_on && m_unf && i_res_tiny[0] |=> o_res_flush[0]
            && ctrl_q[simdfe_pkg::BIT_UNDERFLOW_FLAG] && ctrl_q[simdfe_pkg::BIT_INEXACT_FLAG];
    endproperty
    a_flush: assert property (p_flush) else $error("flush not applied");

    property p_no_denorm_convert;
        take_op && no_denorm_kind |-> !flag_set[simdfe_pkg::BIT_DENORMAL_FLAG];
    endproperty
    a_no_denorm_convert: assert property (p_no_denorm_convert) else $error("bad denorm");

endmodule : simdfe_exception_unit

`default_nettype wire

//--- simdfe_exception_unit_tb.sv
`default_nettype none

module simdfe_exception_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Signals and design instance
    // ---------------------------------------------------------------
    localparam logic [31:0] EV_GO = 32'h8;
    localparam logic [31:0] EV_COMMIT = 32'h4;
    localparam logic [31:0] EV_SIMD = 32'h2;
    localparam logic [31:0] EV_OPC = 32'h1;
    localparam logic [31:0] MASKS = 32'h0000_1f80;

    logic i_clk, i_reset_n, i_clk_en, i_wr, i_rd, i_op_valid, i_res_valid, i_handler_return;
    logic o_busy, o_compute_go, o_commit, o_hold_operands, o_simd_fp_fault;
    logic o_invalid_opcode_fault;
    logic [simdfe_pkg::ADDR_W-1:0] i_addr;
    logic [31:0] i_wdata, i_system_control_reg, o_rdata;
    logic [2:0] i_op_kind;
    logic [simdfe_pkg::LANES-1:0] i_lane_en, i_src_snan, i_src_qnan, i_src_bad_arith;
    logic [simdfe_pkg::LANES-1:0] i_src_denormal, i_src_sign, i_divisor_zero;
    logic [simdfe_pkg::LANES-1:0] i_dividend_finite_nz, i_res_overflow, i_res_tiny;
    logic [simdfe_pkg::LANES-1:0] i_res_inexact, i_res_sign, o_src_zero, o_src_zero_sign;
    logic [simdfe_pkg::LANES-1:0] o_res_flush, o_res_flush_sign;
    logic [simdfe_pkg::LANES-1:0] r_ovf, r_tiny, r_inex, r_sign, lanes;
    logic [31:0] exp_q[$];
    logic rd_d = 1'b0;
    int failures = 0;
    int checked = 0;
    wire logic [31:0] ev_code = {28'h0, o_compute_go, o_commit, o_simd_fp_fault,
        o_invalid_opcode_fault};

    simdfe_exception_unit simdfe_exception_unit_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_system_control_reg(i_system_control_reg), .i_op_valid(i_op_valid),
        .i_op_kind(i_op_kind), .i_lane_en(i_lane_en), .i_src_snan(i_src_snan),
        .i_src_qnan(i_src_qnan), .i_src_bad_arith(i_src_bad_arith),
        .i_src_denormal(i_src_denormal), .i_src_sign(i_src_sign),
        .i_divisor_zero(i_divisor_zero), .i_dividend_finite_nz(i_dividend_finite_nz),
        .i_res_valid(i_res_valid), .i_res_overflow(i_res_overflow), .i_res_tiny(i_res_tiny),
        .i_res_inexact(i_res_inexact), .i_res_sign(i_res_sign),
        .i_handler_return(i_handler_return), .o_busy(o_busy), .o_compute_go(o_compute_go),
        .o_commit(o_commit), .o_hold_operands(o_hold_operands),
        .o_simd_fp_fault(o_simd_fp_fault), .o_invalid_opcode_fault(o_invalid_opcode_fault),
        .o_src_zero(o_src_zero), .o_src_zero_sign(o_src_zero_sign),
        .o_res_flush(o_res_flush), .o_res_flush_sign(o_res_flush_sign)
    );

    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
        $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ---------------------------------------------------------------
    // Result watcher: every read answer and every pulse takes one note.
    // ---------------------------------------------------------------
    task automatic take(input logic [31:0] got);
        logic [31:0] want;
        if (exp_q.size() == 0)
        begin
            failures++;
            $display("unexpected at %0t: result %h with nothing expected", $time, got);
        end
        else
        begin
            want = exp_q.pop_front();
            `CHK(got, want)
        end
    endtask : take

    always @(posedge i_clk)
    begin
        rd_d <= i_rd;
        if (rd_d)
            take(o_rdata);
        if (ev_code != 32'h0)
            take(ev_code);
    end

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask : rd_chk

    // Answers every fault with a handler return and every go with results,
    // so the event order seen by the watcher is the design's own sequence.
    task automatic run_op(input logic [2:0] k, input logic [3:0] snan, input logic [3:0] qnan,
        input logic [3:0] den, input logic [3:0] dz, input logic [3:0] dnz);
        logic done;
        done = 1'b0;
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op_kind <= k;
        i_src_snan <= snan;
        i_src_qnan <= qnan;
        i_src_denormal <= den;
        i_src_sign <= r_sign;
        i_divisor_zero <= dz;
        i_dividend_finite_nz <= dnz;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge i_clk);
            if (o_simd_fp_fault || o_invalid_opcode_fault)
                `CHK(o_hold_operands, 1'b1)
            if (o_compute_go || o_commit)
                `CHK(o_busy, o_compute_go)
            i_handler_return <= o_simd_fp_fault | o_invalid_opcode_fault;
            i_res_valid <= o_compute_go;
            i_res_overflow <= r_ovf;
            i_res_tiny <= r_tiny;
            i_res_inexact <= r_inex;
            i_res_sign <= r_sign;
            done = o_commit;
        end
        `CHK(done, 1'b1)
        r_ovf = 4'h0;
        r_tiny = 4'h0;
        r_inex = 4'h0;
    endtask : run_op

    task automatic ops(input logic [31:0] a, input logic [31:0] b);
        exp_q.push_back(a);
        exp_q.push_back(b);
    endtask : ops

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #(50 * 6000);
        failures++;
        $display("unexpected at %0t: run did not finish in time", $time);
        tally_and_finish();
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        logic [2:0] kinds[4];
        logic [31:0] want[4];
        void'($urandom(32'hab527d6f));
        {i_reset_n, i_wr, i_rd, i_op_valid, i_res_valid, i_handler_return} = 6'h0;
        {i_addr, i_wdata, i_op_kind} = '0;
        {i_src_snan, i_src_qnan, i_src_bad_arith, i_src_denormal, i_src_sign} = '0;
        {i_divisor_zero, i_dividend_finite_nz, i_res_overflow, i_res_tiny} = '0;
        {i_res_inexact, i_res_sign, r_ovf, r_tiny, r_inex, r_sign} = '0;
        i_clk_en = 1'b1;
        i_lane_en = 4'hf;
        i_system_control_reg = 32'h0000_0400;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_chk(4'h0, MASKS);
        rd_chk(4'h8, 32'h0);
        wr(4'h0, 32'hffff_ffff);
        rd_chk(4'h0, 32'h0000_ffff);
        wr(4'h4, 32'hffff_ffff);
        rd_chk(4'h4, 32'h0);
        $display("test registers done");
        wr(4'h0, MASKS);
        r_sign = 4'($urandom());
        r_ovf = 4'b0100;
        r_tiny = 4'b1000;
        r_inex = 4'b1000;
        ops(EV_GO, EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, 4'b1001, 4'h0, 4'h0);
        rd_chk(4'h0, MASKS | 32'h3a);
        wr(4'h0, MASKS);
        r_tiny = 4'b0001;
        ops(EV_GO, EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rd_chk(4'h0, MASKS);
        wr(4'h0, MASKS & ~32'h800);
        r_tiny = 4'b0010;
        ops(EV_GO, EV_SIMD);
        exp_q.push_back(EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        rd_chk(4'h0, (MASKS & ~32'h800) | 32'h10);
        $display("test masked and underflow done");
        kinds = '{3'h2, 3'h3, 3'h4, 3'h0};
        want = '{32'h1, 32'h1, 32'h0, 32'h0};
        foreach (kinds[i])
        begin
            wr(4'h0, MASKS);
            ops(EV_GO, EV_COMMIT);
            run_op(kinds[i], 4'h0, 4'b0100, 4'h0, 4'h0, 4'h0);
            rd_chk(4'h0, MASKS | want[i]);
        end
        kinds = '{3'h0, 3'h1, 3'h5, 3'h6};
        want = '{32'h2, 32'h2, 32'h0, 32'h0};
        foreach (kinds[i])
        begin
            wr(4'h0, MASKS);
            ops(EV_GO, EV_COMMIT);
            run_op(kinds[i], 4'h0, 4'h0, 4'b0010, 4'h0, 4'h0);
            rd_chk(4'h0, MASKS | want[i]);
        end
        kinds = '{3'h1, 3'h0, 3'h1, 3'h1};
        want = '{32'h4, 32'h0, 32'h0, 32'h4};
        foreach (kinds[i])
        begin
            wr(4'h0, MASKS | 32'h8000);
            ops(EV_GO, EV_COMMIT);
            run_op(kinds[i], 4'h0, 4'h0, 4'h0, 4'b1000, {i != 2, 3'h0});
            rd_chk(4'h0, MASKS | 32'h8000 | want[i]);
        end
        wr(4'h0, MASKS);
        i_lane_en <= 4'h7;
        i_src_bad_arith <= 4'h9;
        ops(EV_GO, EV_COMMIT);
        run_op(3'h2, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8);
        rd_chk(4'h0, MASKS | 32'h1);
        i_lane_en <= 4'hf;
        i_src_bad_arith <= 4'h0;
        $display("test classes done");
        for (int os = 0; os < 2; os++)
        begin
            wr(4'h0, MASKS & ~32'h80);
            i_system_control_reg <= os ? 32'h0000_0400 : 32'h0;
            ops(os ? EV_SIMD : EV_OPC, EV_GO);
            exp_q.push_back(EV_COMMIT);
            run_op(3'h0, 4'b0001, 4'h0, 4'h0, 4'h0, 4'h0);
            rd_chk(4'h0, (MASKS & ~32'h80) | 32'h1);
            rd_chk(4'h4, os ? 32'h0 : 32'h10);
        end
        wr(4'h0, MASKS & ~32'h500);
        r_ovf = 4'b0100;
        r_inex = 4'b1000;
        ops(EV_SIMD, EV_GO);
        ops(EV_SIMD, EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, 4'b0010, 4'h0, 4'h0);
        rd_chk(4'h0, (MASKS & ~32'h500) | 32'h2a);
        $display("test unmasked faults done");
        wr(4'h0, MASKS | 32'h40);
        lanes = 4'($urandom()) | 4'h1;
        r_sign = 4'($urandom());
        ops(EV_GO, EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, lanes, 4'h0, 4'h0);
        `CHK(o_src_zero, lanes)
        `CHK(o_src_zero_sign & lanes, r_sign & lanes)
        rd_chk(4'h0, MASKS | 32'h40);
        wr(4'h0, MASKS | 32'h8000);
        lanes = 4'($urandom()) | 4'h5;
        r_tiny = lanes;
        ops(EV_GO, EV_COMMIT);
        run_op(3'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        `CHK(o_res_flush, lanes)
        `CHK(o_res_flush_sign & lanes, r_sign & lanes)
        rd_chk(4'h0, MASKS | 32'h8030);
        i_clk_en <= 1'b0;
        wr(4'h0, 32'h0);
        i_clk_en <= 1'b1;
        rd_chk(4'h0, MASKS | 32'h8030);
        $display("test zero options done");
        repeat (4) @(posedge i_clk);
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end

endmodule : simdfe_exception_unit_tb

`default_nettype wire
